// ===== hw/aab_bridge.sv
`timescale 1ns/1ps
// How it works
// - APB address equals AXI address, no remapping.
// - Simultaneous read and write: read accepted first.
// - Pending write starts only after read response completes.
// - No exclusive access, never EXOKAY.
// - Little-endian both sides, byte lanes map directly.
// - Write and read data pass unchanged.
// - APB4 drives strobes and protection.
// - Protection from read or write channel.
// - Slave error becomes SLVERR response.
// - Never answer DECERR.
// - Timeout logic exists only for non-zero count.
// - Timeout ends transfer with SLVERR, zero data.
// - Timeout counter decrements while transfer active.
// - Slave acknowledge reloads the timeout counter.
// - One clock drives both interfaces.
// - Synchronous reset clears AXI and APB logic.
// - Slave chosen by inclusive base/high range.
// - One select per slave, only addressed one.
// - Strobes stay low during reads.
// - Enable from second cycle until transfer ends.
`include "aab_defines.svh"

module aab_bridge #(
	parameter int NUM_SLV = 4,
	parameter bit APB4 = 1'b1,
	parameter int TIMEOUT = 64,
	parameter logic [NUM_SLV-1:0][31:0] SLV_BASE =
		{32'h0000_3000, 32'h0000_2000, 32'h0000_1000, 32'h0000_0000},
	parameter logic [NUM_SLV-1:0][31:0] SLV_HIGH =
		{32'h0000_3fff, 32'h0000_2fff, 32'h0000_1fff, 32'h0000_0fff}
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] m_apb_paddr,
	output logic [NUM_SLV-1:0] m_apb_psel,
	output logic m_apb_penable,
	output logic m_apb_pwrite,
	output logic [31:0] m_apb_pwdata,
	output logic [3:0] m_apb_pstrb,
	output logic [2:0] m_apb_pprot,
	input wire logic [NUM_SLV-1:0] m_apb_pready,
	input wire logic [NUM_SLV-1:0][31:0] m_apb_prdata,
	input wire logic [NUM_SLV-1:0] m_apb_pslverr
);

	localparam int IW = (NUM_SLV > 1) ? $clog2(NUM_SLV) : 1;
	localparam int TW = (TIMEOUT > 0) ? $clog2(TIMEOUT + 1) : 1;

	aab_pkg::aab_state_t state_ff;
	logic arready_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic rvalid_ff;
	logic [1:0] bresp_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	logic [31:0] paddr_ff;
	logic [NUM_SLV-1:0] psel_ff;
	logic penable_ff;
	logic pwrite_ff;
	logic [31:0] pwdata_ff;
	logic [3:0] pstrb_ff;
	logic [2:0] pprot_ff;
	logic [IW-1:0] sel_idx_ff;
	logic [NUM_SLV-1:0] hit;
	logic [IW-1:0] hit_idx;
	logic found;
	logic ack;
	logic slv_err;
	logic tmo_hit;
	logic done;
	logic [31:0] prdata_sel;

	// Address decode; the lowest matching slave wins if ranges overlap.
	always_comb
	begin
		hit = '0;
		hit_idx = '0;
		found = 1'b0;
		for (int i = 0; i < NUM_SLV; i++)
		begin
			if (!found && paddr_ff >= SLV_BASE[i] && paddr_ff <= SLV_HIGH[i])
			begin
				hit[i] = 1'b1;
				hit_idx = IW'(i);
				found = 1'b1;
			end
		end
	end

	assign ack = |(psel_ff & m_apb_pready);
	assign slv_err = |(psel_ff & m_apb_pslverr);
	assign prdata_sel = m_apb_prdata[sel_idx_ff];
	// A ready in the same cycle as expiry still counts as a normal answer.
	assign done = penable_ff && (ack || tmo_hit);

	generate
		if (TIMEOUT != 0)
		begin : g_tmo
			logic [TW-1:0] tmo_ff;

			always_ff @(posedge clk)
			begin
				if (rst)
					tmo_ff <= TW'(TIMEOUT);
				else if (state_ff == aab_pkg::st_setup || (penable_ff && ack))
					tmo_ff <= TW'(TIMEOUT);
				else if (penable_ff && tmo_ff != '0)
					tmo_ff <= tmo_ff - TW'(1);
			end

			assign tmo_hit = penable_ff && !ack && (tmo_ff == TW'(`AAB_TMO_LAST));
		end
		else
		begin : g_no_tmo
			assign tmo_hit = 1'b0;
		end
	endgenerate

	// Main sequence: accept, APB setup and access phases, then AXI response.
	always_ff @(posedge clk)
	begin
		if (rst)
			state_ff <= aab_pkg::st_idle;
		else
		begin
			case (state_ff)
				aab_pkg::st_idle:
				begin
					if (s_axi_arvalid)
						state_ff <= aab_pkg::st_racc;
					else if (s_axi_awvalid && s_axi_wvalid)
						state_ff <= aab_pkg::st_wacc;
				end
				aab_pkg::st_racc,
				aab_pkg::st_wacc:
					state_ff <= aab_pkg::st_setup;
				aab_pkg::st_setup:
					state_ff <= found ? aab_pkg::st_access : aab_pkg::st_resp;
				aab_pkg::st_access:
				begin
					if (done)
						state_ff <= aab_pkg::st_resp;
				end
				aab_pkg::st_resp:
				begin
					if ((bvalid_ff && s_axi_bready) || (rvalid_ff && s_axi_rready))
						state_ff <= aab_pkg::st_idle;
				end
				default:
					state_ff <= aab_pkg::st_idle;
			endcase
		end
	end

	// Ready is raised for exactly the one cycle in which valid is already held.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			arready_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
		end
		else
		begin
			arready_ff <= (state_ff == aab_pkg::st_idle) && s_axi_arvalid;
			awready_ff <= (state_ff == aab_pkg::st_idle) && !s_axi_arvalid &&
				s_axi_awvalid && s_axi_wvalid;
			wready_ff <= (state_ff == aab_pkg::st_idle) && !s_axi_arvalid &&
				s_axi_awvalid && s_axi_wvalid;
		end
	end

	// Request capture; address and data pass through untouched.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			paddr_ff <= `AAB_RST_ADDR;
			pwrite_ff <= 1'b0;
			pwdata_ff <= `AAB_RST_DATA;
			pstrb_ff <= `AAB_RST_STRB;
			pprot_ff <= `AAB_RST_PROT;
		end
		else if (state_ff == aab_pkg::st_racc)
		begin
			paddr_ff <= s_axi_araddr;
			pwrite_ff <= 1'b0;
			pstrb_ff <= `AAB_RST_STRB;
			pprot_ff <= APB4 ? s_axi_arprot : `AAB_RST_PROT;
		end
		else if (state_ff == aab_pkg::st_wacc)
		begin
			paddr_ff <= s_axi_awaddr;
			pwrite_ff <= 1'b1;
			pwdata_ff <= s_axi_wdata;
			pstrb_ff <= APB4 ? s_axi_wstrb : `AAB_RST_STRB;
			pprot_ff <= APB4 ? s_axi_awprot : `AAB_RST_PROT;
		end
	end

	// APB select and enable phases.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			psel_ff <= '0;
			penable_ff <= 1'b0;
			sel_idx_ff <= '0;
		end
		else if (state_ff == aab_pkg::st_setup)
		begin
			psel_ff <= hit;
			sel_idx_ff <= hit_idx;
		end
		else if (state_ff == aab_pkg::st_access)
		begin
			if (done)
			begin
				psel_ff <= '0;
				penable_ff <= 1'b0;
			end
			else
				penable_ff <= 1'b1;
		end
	end

	// AXI responses; only OKAY or SLVERR are ever produced.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rvalid_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			rresp_ff <= `AAB_RESP_OKAY;
			bresp_ff <= `AAB_RESP_OKAY;
			rdata_ff <= `AAB_RST_DATA;
		end
		else if ((state_ff == aab_pkg::st_setup && !found) ||
			(state_ff == aab_pkg::st_access && done))
		begin
			if (pwrite_ff)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff <= (ack && !slv_err) ? `AAB_RESP_OKAY : `AAB_RESP_SLVERR;
			end
			else
			begin
				rvalid_ff <= 1'b1;
				rresp_ff <= (ack && !slv_err) ? `AAB_RESP_OKAY : `AAB_RESP_SLVERR;
				rdata_ff <= ack ? prdata_sel : `AAB_RST_DATA;
			end
		end
		else
		begin
			if (s_axi_rready)
				rvalid_ff <= 1'b0;
			if (s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_arready = arready_ff;
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign m_apb_paddr = paddr_ff;
	assign m_apb_psel = psel_ff;
	assign m_apb_penable = penable_ff;
	assign m_apb_pwrite = pwrite_ff;
	assign m_apb_pwdata = pwdata_ff;
	assign m_apb_pstrb = pstrb_ff;
	assign m_apb_pprot = pprot_ff;

	// Counts access-phase cycles for the wait-bound check.
	logic [31:0] wait_cnt_ff;

	always_ff @(posedge clk)
	begin
		if (rst || !penable_ff)
			wait_cnt_ff <= '0;
		else
			wait_cnt_ff <= wait_cnt_ff + 32'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_no_decerr: assert property (!(s_axi_bvalid && s_axi_bresp == `AAB_RESP_DECERR) &&
		!(s_axi_rvalid && s_axi_rresp == `AAB_RESP_DECERR))
		else $error("DECERR response driven");

	a_no_exokay: assert property (!(s_axi_rvalid && s_axi_rresp == `AAB_RESP_EXOKAY) &&
		!(s_axi_bvalid && s_axi_bresp == `AAB_RESP_EXOKAY))
		else $error("EXOKAY response driven");

	a_addr_pass: assert property (s_axi_arvalid && s_axi_arready |=>
		m_apb_paddr == $past(s_axi_araddr) && !m_apb_pwrite)
		else $error("APB address differs from AXI read address");

	a_read_first: assert property (s_axi_arvalid && s_axi_awvalid && s_axi_wvalid &&
		state_ff == aab_pkg::st_idle |=> s_axi_arready && !s_axi_awready)
		else $error("Write accepted ahead of read");

	a_one_psel: assert property ($onehot0(m_apb_psel))
		else $error("More than one select active");

	a_penable_seq: assert property ((m_apb_psel != '0) && !m_apb_penable |=>
		m_apb_penable && $stable(m_apb_psel))
		else $error("Enable missing in second cycle");

	a_penable_hold: assert property (m_apb_penable && !ack && !tmo_hit |=> m_apb_penable)
		else $error("Enable dropped during wait");

	a_strb_read: assert property ((m_apb_psel != '0) && !m_apb_pwrite |->
		m_apb_pstrb == `AAB_RST_STRB)
		else $error("Strobes active during read");

	a_slverr_map: assert property (m_apb_penable && ack && slv_err && !m_apb_pwrite |=>
		s_axi_rvalid && s_axi_rresp == `AAB_RESP_SLVERR)
		else $error("Slave error not reported");

	a_rdata_pass: assert property (m_apb_penable && ack && !m_apb_pwrite |=>
		s_axi_rvalid && s_axi_rdata == $past(prdata_sel))
		else $error("Read data altered");

	a_tmo_zero: assert property (m_apb_penable && tmo_hit && !m_apb_pwrite |=>
		s_axi_rvalid && s_axi_rdata == `AAB_RST_DATA && s_axi_rresp == `AAB_RESP_SLVERR)
		else $error("Timeout read not answered with zero SLVERR");

	a_wait_bound: assert property ((TIMEOUT == 0) || wait_cnt_ff <= TIMEOUT)
		else $error("Access phase outlived the timeout");

	a_one_xfer: assert property (s_axi_bvalid || s_axi_rvalid |-> m_apb_psel == '0)
		else $error("Response overlaps APB transfer");

	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
	c_write_done: cover property (s_axi_bvalid && s_axi_bready);
	c_timeout: cover property (tmo_hit);
	c_both_req: cover property (s_axi_arvalid && s_axi_awvalid && s_axi_wvalid &&
		state_ff == aab_pkg::st_idle);

endmodule

// ===== pkg/aab_defines.svh
`ifndef AAB_DEFINES_SVH
`define AAB_DEFINES_SVH

// Response codes on the AXI read and write response channels.
`define AAB_RESP_OKAY 2'h0
`define AAB_RESP_EXOKAY 2'h1
`define AAB_RESP_SLVERR 2'h2
`define AAB_RESP_DECERR 2'h3

// Reset values of the registered outputs.
`define AAB_RST_ADDR 32'h0000_0000
`define AAB_RST_DATA 32'h0000_0000
`define AAB_RST_STRB 4'h0
`define AAB_RST_PROT 3'h0

// Counter value at which the last allowed wait cycle is spent.
`define AAB_TMO_LAST 1

`endif

// ===== pkg/aab_pkg.sv
package aab_pkg;

	typedef enum logic [2:0]
	{
		st_idle = 3'h0,
		st_racc = 3'h1,
		st_wacc = 3'h2,
		st_setup = 3'h3,
		st_access = 3'h4,
		st_resp = 3'h5
	} aab_state_t;

endpackage

// ===== dv/aab_apb_slave_model.sv
`timescale 1ns/1ps
module aab_apb_slave_model #(
	parameter int NUM_SLV = 4
)
(
	input wire logic clk,
	input wire logic [NUM_SLV-1:0] psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [7:0] wait_cycles,
	input wire logic inject_err,
	input wire logic hang,
	output logic [NUM_SLV-1:0] pready,
	output logic [NUM_SLV-1:0][31:0] prdata,
	output logic [NUM_SLV-1:0] pslverr
);
	logic [7:0] cnt = 8'h0;
	logic [31:0] junk = 32'h0;
	always @(posedge clk)
	begin
		cnt <= penable ? cnt + 8'h1 : 8'h0;
		junk <= junk + 32'h1357_9bdf;
	end
	// Outside a read answer the data lines change every cycle.
	always_comb
	begin
		for (int i = 0; i < NUM_SLV; i++)
		begin
			pready[i] = psel[i] && penable && !hang && cnt >= wait_cycles;
			pslverr[i] = pready[i] && inject_err;
			prdata[i] = (pready[i] && !pwrite) ? paddr ^ 32'h5a5a_a5a5 : junk ^ 32'(i);
		end
	end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
`include "aab_defines.svh"
module testbench;
	localparam int TMO = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, m_apb_paddr, m_apb_pwdata, c_addr, c_wd;
	logic [3:0] m_apb_psel, m_apb_pready, m_apb_pslverr, m_apb_pstrb, c_st, c_sel;
	logic m_apb_penable, m_apb_pwrite, c_wr;
	logic [2:0] m_apb_pprot, c_pr;
	logic [3:0][31:0] m_apb_prdata;
	logic [7:0] wcyc = 8'h0;
	logic err = 1'b0;
	logic hang = 1'b0;
	int bad_count = 0;
	int num_checks = 0;
	time t_ar, t_aw, t_rd;
	aab_bridge #(.TIMEOUT(TMO)) u_aab_bridge (.clk, .rst, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .m_apb_paddr, .m_apb_psel, .m_apb_penable,
		.m_apb_pwrite, .m_apb_pwdata, .m_apb_pstrb, .m_apb_pprot, .m_apb_pready,
		.m_apb_prdata, .m_apb_pslverr);
	aab_apb_slave_model #(.NUM_SLV(4)) u_aab_apb_slave_model (.clk, .psel(m_apb_psel),
		.penable(m_apb_penable), .pwrite(m_apb_pwrite), .paddr(m_apb_paddr),
		.wait_cycles(wcyc), .inject_err(err), .hang, .pready(m_apb_pready),
		.prdata(m_apb_prdata), .pslverr(m_apb_pslverr));
	always #20 clk = ~clk;
	always @(posedge clk)
		if (m_apb_penable === 1'b1 && |(m_apb_pready & m_apb_psel))
		begin
			c_addr <= m_apb_paddr;
			c_wd <= m_apb_pwdata;
			c_st <= m_apb_pstrb;
			c_pr <= m_apb_pprot;
			c_sel <= m_apb_psel;
			c_wr <= m_apb_pwrite;
		end
	function automatic logic [31:0] exp_rd(input logic [31:0] a);
		return a ^ 32'h5a5a_a5a5;
	endfunction
	function automatic logic [31:0] exp_sel(input logic [31:0] a);
		return 32'h1 << a[13:12];
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input string nm, input int k);
		int n;
		logic s;
		n = 0;
		s = 1'b0;
		while (s !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
			s = k == 0 ? s_axi_arready : k == 1 ? s_axi_awready : k == 2 ? s_axi_rvalid : s_axi_bvalid;
		end
		if (s !== 1'b1)
		begin
			bad_count++;
			$display("BAD %s expected 1 seen %b", nm, s);
		end
	endtask
	task automatic rd(input logic [31:0] a, input logic [2:0] p, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		#1;
		s_axi_araddr = a;
		s_axi_arprot = p;
		s_axi_arvalid = 1'b1;
		s_axi_rready = 1'b1;
		wt("arready", 0);
		t_ar = $time;
		#1;
		s_axi_arvalid = 1'b0;
		wt("rvalid", 2);
		d = s_axi_rdata;
		r = s_axi_rresp;
		t_rd = $time;
		#1;
		s_axi_rready = 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [2:0] p, output logic [1:0] r);
		@(posedge clk);
		#1;
		s_axi_awaddr = a;
		s_axi_wdata = d;
		s_axi_wstrb = s;
		s_axi_awprot = p;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h7;
		wt("awready", 1);
		chk("wready", 32'h1, 32'(s_axi_wready));
		t_aw = $time;
		#1;
		{s_axi_awvalid, s_axi_wvalid} = 2'h0;
		wt("bvalid", 3);
		r = s_axi_bresp;
		#1;
		s_axi_bready = 1'b0;
	endtask
	task automatic pair(input logic [31:0] a, input logic [7:0] w, input logic e);
		logic [31:0] d, wd;
		logic [1:0] r, er;
		logic [3:0] st;
		logic [2:0] pw, pr;
		wd = $urandom;
		st = 4'($urandom);
		pw = 3'($urandom);
		pr = 3'($urandom);
		wcyc = w;
		err = e;
		er = e ? `AAB_RESP_SLVERR : `AAB_RESP_OKAY;
		wr(a, wd, st, pw, r);
		chk("bresp", 32'(er), 32'(r));
		chk("paddr", a, c_addr);
		chk("pwdata", wd, c_wd);
		chk("pstrb", 32'(st), 32'(c_st));
		chk("pprot", 32'(pw), 32'(c_pr));
		chk("psel", exp_sel(a), 32'(c_sel));
		chk("pwrite", 32'h1, 32'(c_wr));
		rd(a, pr, d, r);
		chk("rresp", 32'(er), 32'(r));
		chk("rdata", exp_rd(a), d);
		chk("rd pstrb", 32'h0, 32'(c_st));
		chk("rd pprot", 32'(pr), 32'(c_pr));
		chk("rd paddr", a, c_addr);
		chk("rd pwrite", 32'h0, 32'(c_wr));
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#(40 * 6000);
		bad_count++;
		$display("BAD watchdog expected finish seen timeout");
		complete_run;
	end
	initial
	begin
		logic [31:0] d;
		logic [1:0] r, r2;
		void'($urandom(45));
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 24; i++)
			pair({18'h0, 2'($urandom), i == 0 ? 12'h0 : i == 1 ? 12'hfff : 12'($urandom)},
				i == 2 ? 8'(TMO - 1) : 8'($urandom_range(3)), i > 2 && $urandom_range(3) == 0);
		$display("random transfers done");
		err = 1'b0;
		wcyc = 8'h2;
		fork
			rd(32'h1008, 3'h2, d, r);
			wr(32'h3010, 32'hcafe_0123, 4'h5, 3'h1, r2);
		join
		chk("read first", 32'h1, 32'(t_ar < t_aw));
		chk("write after read", 32'h1, 32'(t_rd < t_aw));
		chk("both rdata", exp_rd(32'h1008), d);
		chk("both resp", 32'h0, 32'({r, r2}));
		chk("both last paddr", 32'h3010, c_addr);
		chk("both last pwdata", 32'hcafe_0123, c_wd);
		$display("simultaneous test done");
		hang = 1'b1;
		wr(32'h2004, 32'h1, 4'hf, 3'h0, r);
		chk("tmo bresp", 32'(`AAB_RESP_SLVERR), 32'(r));
		rd(32'h2004, 3'h0, d, r);
		chk("tmo rresp", 32'(`AAB_RESP_SLVERR), 32'(r));
		chk("tmo rdata", 32'h0, d);
		hang = 1'b0;
		$display("timeout test done");
		wr(32'h0001_0000, 32'h1, 4'hf, 3'h0, r);
		chk("unmapped bresp", 32'(`AAB_RESP_SLVERR), 32'(r));
		rd(32'h0001_0000, 3'h0, d, r);
		chk("unmapped rresp", 32'(`AAB_RESP_SLVERR), 32'(r));
		chk("unmapped rdata", 32'h0, d);
		$display("unmapped test done");
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("reset idle", 32'h0, 32'({m_apb_psel, m_apb_penable, s_axi_rvalid, s_axi_bvalid}));
		chk("reset paddr", 32'h0, m_apb_paddr);
		pair(32'h0000_0ffc, 8'h0, 1'b0);
		$display("reset test done");
		complete_run;
	end
endmodule
